// file: rtl/lpc_pkg.sv
// constants for the low-power state and clock gating control block
// assumes one core clock domain, synchronous active-high reset
// Summary of operation
// [R1] role force bit overrides clock-control master/slave
// [R2] mux force bit overrides system clock select
// [R3] twelve gating-disable bits, reset to zero
// [R4] set disable bit keeps that clock running
// [R5] force enable holds state at programmed value
// [R6] energy detection only while enable set
// [R7] sleep entry blocked unless permit set
// [R8] autonomous bit picks normal or standby start; bit is zero until INIT is left, so start is always standby
// [R9] monitor fault moves normal to standby if enabled
// [R10] standby request bit pulses, then self-clears
// [R11] normal request bit pulses, then self-clears
// [R12] standby is 0x2, normal is 0x4
// [R13] zero writes to the mode request register ignored, reserved bits read zero
package lpc_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 16;
    localparam int          STATE_W         = 7;
    localparam int          GATE_W          = 12;
    localparam logic [11:0] ADDR_CLK_CTRL   = 12'h182;
    localparam logic [11:0] ADDR_PS_FORCE   = 12'h183;
    localparam logic [11:0] ADDR_PF_EN      = 12'h18b;
    localparam logic [11:0] ADDR_MODE_REQ   = 12'h18c;
    localparam logic [11:0] ADDR_PS_OBS     = 12'h18e;
    localparam int          BIT_ROLE_VAL    = 15;
    localparam int          BIT_ROLE_EN     = 14;
    localparam int          BIT_MUX_VAL     = 13;
    localparam int          BIT_MUX_EN      = 12;
    localparam int          GATE_MSB        = 11;
    localparam int          BIT_FORCE_EN    = 7;
    localparam int          FORCE_MSB       = 6;
    localparam int          BIT_DETECT_EN   = 8;
    localparam int          BIT_SLEEP_EN    = 7;
    localparam int          BIT_AUTO_MODE   = 6;
    localparam int          BIT_MON_EN      = 5;
    localparam int          PF_RW_MSB       = 4;
    localparam int          BIT_REQ_STANDBY = 4;
    localparam int          BIT_REQ_NORMAL  = 0;
    localparam logic [6:0]  ST_STANDBY      = 7'h02;
    localparam logic [6:0]  ST_NORMAL       = 7'h04;
    localparam logic [6:0]  ST_SLEEP        = 7'h08;
    localparam logic [6:0]  ST_INIT         = 7'h01;
endpackage

// file: rtl/lpc_sync2.sv
// two-flop synchroniser for asynchronous level inputs
// assumes the destination runs on core_clk
`timescale 1ns/1ns
`default_nettype none
module lpc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: rtl/lpc_clk_gate_en.sv
// per-clock enable combining automatic gating and software keep-on
// assumes auto requests come from core_clk logic
`timescale 1ns/1ns
`default_nettype none
module lpc_clk_gate_en #(
    parameter int N = 12
) (
    input  wire logic [N-1:0] auto_run,
    input  wire logic [N-1:0] gate_disable,
    output logic      [N-1:0] clk_enable
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_en
            // [R4] disable bit forces on
            assign clk_enable[i] = auto_run[i] | gate_disable[i];
        end
    endgenerate
endmodule
`default_nettype wire

// file: rtl/lpc_ctrl.sv
// low-power state machine control, clock override and gating registers
// assumes a plain register port on core_clk; fault inputs are asynchronous
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module lpc_ctrl #(
    parameter int GATE_W = lpc_pkg::GATE_W
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic [lpc_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [lpc_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [lpc_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        role_normal,
    input  wire logic                        sysclk_mux_internal,
    input  wire logic [GATE_W-1:0]           gate_auto_run,
    input  wire logic                        over_temp,
    input  wire logic                        under_volt,
    input  wire logic                        energy_seen,
    input  wire logic                        sleep_cond,
    output logic                             role_select,
    output logic                             sysclk_mux_select,
    output logic      [GATE_W-1:0]           clk_enable,
    output logic                             energy_detect_enable,
    output logic                             energy_detected,
    output logic      [lpc_pkg::STATE_W-1:0] power_state_observe
);
    typedef enum logic [3:0] {
        LPC_INIT    = 4'h1,
        LPC_STANDBY = 4'h2,
        LPC_NORMAL  = 4'h4,
        LPC_SLEEP   = 4'h8
    } lpc_state_t;

    logic [lpc_pkg::DATA_W-1:0]      clk_ctrl;
    logic [lpc_pkg::STATE_W:0]       ps_force;
    logic [lpc_pkg::BIT_DETECT_EN:0] pf_en;
    lpc_state_t                      state;
    lpc_state_t                      next_state;
    logic                            over_temp_sync;
    logic                            under_volt_sync;
    logic                            energy_sync;
    logic                            sleep_sync;
    logic                            auto_taken;

    // each pin synchronised on its own, combined only afterwards
    lpc_sync2 #(
        .W(4)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({over_temp, under_volt, energy_seen, sleep_cond}),
        .sync_out ({over_temp_sync, under_volt_sync, energy_sync, sleep_sync})
    );

    wire fault_sync = over_temp_sync | under_volt_sync;

    wire sel_clk  = reg_addr == lpc_pkg::ADDR_CLK_CTRL;
    wire sel_psf  = reg_addr == lpc_pkg::ADDR_PS_FORCE;
    wire sel_pf   = reg_addr == lpc_pkg::ADDR_PF_EN;
    wire sel_req  = reg_addr == lpc_pkg::ADDR_MODE_REQ;
    wire sel_obs  = reg_addr == lpc_pkg::ADDR_PS_OBS;
    wire wr_clk   = reg_wr & sel_clk;
    wire wr_psf   = reg_wr & sel_psf;
    wire wr_pf    = reg_wr & sel_pf;
    // [R10] standby command pulse
    wire req_stby = reg_wr & sel_req & reg_wdata[lpc_pkg::BIT_REQ_STANDBY];
    // [R11] normal command pulse
    wire req_norm = reg_wr & sel_req & reg_wdata[lpc_pkg::BIT_REQ_NORMAL];

    wire force_en   = ps_force[lpc_pkg::BIT_FORCE_EN];
    wire detect_on  = pf_en[lpc_pkg::BIT_DETECT_EN];
    wire sleep_ok   = pf_en[lpc_pkg::BIT_SLEEP_EN];
    wire auto_mode  = pf_en[lpc_pkg::BIT_AUTO_MODE];
    wire mon_en     = pf_en[lpc_pkg::BIT_MON_EN];

    // [R1] role override
    assign role_select = clk_ctrl[lpc_pkg::BIT_ROLE_EN] ? clk_ctrl[lpc_pkg::BIT_ROLE_VAL] : role_normal;
    // [R2] mux select override
    assign sysclk_mux_select = clk_ctrl[lpc_pkg::BIT_MUX_EN] ? clk_ctrl[lpc_pkg::BIT_MUX_VAL]
                                                            : sysclk_mux_internal;
    // [R6] detection gated by enable
    assign energy_detect_enable = detect_on;
    assign energy_detected      = detect_on & energy_sync;

    lpc_clk_gate_en #(
        .N(GATE_W)
    ) u_gate (
        .auto_run     (gate_auto_run),
        .gate_disable (clk_ctrl[GATE_W-1:0]),
        .clk_enable   (clk_enable)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            LPC_INIT: begin
                // [R8] power-up mode choice
                next_state = auto_mode ? LPC_NORMAL : LPC_STANDBY;
            end
            LPC_STANDBY: begin
                if (req_norm) begin
                    next_state = LPC_NORMAL;
                end else if (sleep_ok & sleep_sync & ~req_stby) begin
                    next_state = LPC_SLEEP;
                end
            end
            LPC_NORMAL: begin
                // normal request wins over standby
                if (req_norm) begin
                    next_state = LPC_NORMAL;
                // [R9] monitor-driven standby
                end else if (req_stby | (mon_en & fault_sync)) begin
                    next_state = LPC_STANDBY;
                end else if (sleep_ok & sleep_sync) begin
                    // [R7] sleep needs permit
                    next_state = LPC_SLEEP;
                end
            end
            LPC_SLEEP: begin
                if (req_norm) begin
                    next_state = LPC_NORMAL;
                end else if (req_stby | ~sleep_ok) begin
                    next_state = LPC_STANDBY;
                end
            end
            default: next_state = LPC_STANDBY;
        endcase
    end

    wire [lpc_pkg::STATE_W-1:0] sm_code =
        (state == LPC_NORMAL) ? lpc_pkg::ST_NORMAL :
        (state == LPC_SLEEP)  ? lpc_pkg::ST_SLEEP  :
        (state == LPC_INIT)   ? lpc_pkg::ST_INIT   : lpc_pkg::ST_STANDBY;
    // [R5] forced state value
    // [R12] shared state encoding
    wire [lpc_pkg::STATE_W-1:0] next_observe = force_en ? ps_force[lpc_pkg::FORCE_MSB:0] : sm_code;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= LPC_INIT;
        end else if (!force_en) begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            power_state_observe <= lpc_pkg::ST_INIT;
        end else begin
            power_state_observe <= next_observe;
        end
    end

    // [R3] gating disable field
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_ctrl <= '0;
        end else if (wr_clk) begin
            clk_ctrl <= reg_wdata;
        end
    end

    // [R13] reserved bits dropped
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ps_force <= '0;
        end else if (wr_psf) begin
            ps_force <= reg_wdata[lpc_pkg::STATE_W:0];
        end
    end

    // [R8] device sets autonomous bit once
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pf_en      <= '0;
            auto_taken <= 1'h0;
        end else begin
            if (wr_pf) begin
                pf_en <= reg_wdata[lpc_pkg::BIT_DETECT_EN:0];
            end
            if (!auto_taken && state != LPC_INIT) begin
                auto_taken                    <= 1'h1;
                pf_en[lpc_pkg::BIT_AUTO_MODE] <= 1'h1;
            end
        end
    end

    // [R10] request bits read back zero
    // [R11] self-clear after pulse
    wire [lpc_pkg::DATA_W-1:0] rd_mux =
        sel_clk ? clk_ctrl :
        sel_psf ? {{(lpc_pkg::DATA_W-lpc_pkg::STATE_W-1){1'b0}}, ps_force} :
        sel_pf  ? {{(lpc_pkg::DATA_W-lpc_pkg::BIT_DETECT_EN-1){1'b0}}, pf_en} :
        sel_obs ? {{(lpc_pkg::DATA_W-lpc_pkg::STATE_W){1'b0}}, power_state_observe} :
                  16'h0000;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule
`default_nettype wire

// file: verif/lpc_ctrl_props.sv
// port-level assertions for the low-power control block
// assumes a bind onto lpc_ctrl, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module lpc_ctrl_props #(
    parameter int GATE_W = 12
) (
    input wire logic                        core_clk,
    input wire logic                        rst,
    input wire logic [lpc_pkg::ADDR_W-1:0]  reg_addr,
    input wire logic [lpc_pkg::DATA_W-1:0]  reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [lpc_pkg::DATA_W-1:0]  reg_rdata,
    input wire logic                        role_normal,
    input wire logic                        sysclk_mux_internal,
    input wire logic [GATE_W-1:0]           gate_auto_run,
    input wire logic                        role_select,
    input wire logic                        sysclk_mux_select,
    input wire logic [GATE_W-1:0]           clk_enable,
    input wire logic                        energy_detect_enable,
    input wire logic                        energy_detected,
    input wire logic [lpc_pkg::STATE_W-1:0] power_state_observe
);
    logic [15:0] cc;
    logic [7:0]  ps;
    logic        ed;
    // shadows of the writable fields
    wire wr_cc = reg_wr && reg_addr == lpc_pkg::ADDR_CLK_CTRL;
    wire wr_ps = reg_wr && reg_addr == lpc_pkg::ADDR_PS_FORCE;
    wire wr_pf = reg_wr && reg_addr == lpc_pkg::ADDR_PF_EN;
    wire wr_mr = reg_wr && reg_addr == lpc_pkg::ADDR_MODE_REQ && !ps[7];
    always_ff @(posedge core_clk) cc <= rst ? 16'h0 : (wr_cc ? reg_wdata : cc);
    always_ff @(posedge core_clk) ps <= rst ? 8'h0 : (wr_ps ? reg_wdata[7:0] : ps);
    always_ff @(posedge core_clk) ed <= rst ? 1'h0 : (wr_pf ? reg_wdata[8] : ed);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_req_normal;
        wr_mr && reg_wdata[0];
    endsequence
    sequence s_req_standby;
        wr_mr && reg_wdata[4] && !reg_wdata[0];
    endsequence
    a_role_force: assert property (role_select == (cc[14] ? cc[15] : role_normal))
        else $error("role select wrong");
    a_mux_force: assert property (sysclk_mux_select == (cc[12] ? cc[13] : sysclk_mux_internal))
        else $error("sysclk mux select wrong");
    a_gate_keep: assert property (clk_enable == (gate_auto_run | cc[GATE_W-1:0]))
        else $error("clock enable wrong");
    a_ed_enable: assert property (energy_detect_enable == ed)
        else $error("energy detect enable wrong");
    a_ed_block: assert property (!energy_detect_enable |-> !energy_detected)
        else $error("energy detected while disabled");
    a_req_normal: assert property (s_req_normal |-> ##2 power_state_observe == lpc_pkg::ST_NORMAL)
        else $error("normal request not taken");
    a_req_standby: assert property (s_req_standby |-> ##2 power_state_observe == lpc_pkg::ST_STANDBY)
        else $error("standby request not taken");
    a_force_hold: assert property (ps[7] && $stable(ps) |-> power_state_observe == ps[6:0])
        else $error("forced state not shown");
    a_mode_reads0: assert property (reg_rd && reg_addr == lpc_pkg::ADDR_MODE_REQ |=> reg_rdata == 16'h0)
        else $error("mode request bits not cleared");
    a_rdata_once: assert property (!reg_rd |=> reg_rdata == 16'h0)
        else $error("read data outside read slot");
endmodule
`default_nettype wire

// file: verif/lpc_ctrl_tb_top.sv
// self-checking bench for the low-power control block
// assumes lpc_pkg and lpc_ctrl compiled first
`timescale 1ns/1ns
`default_nettype none
module lpc_ctrl_tb_top;
    logic        core_clk = '0, rst = 1'h1, reg_wr = '0, reg_rd = '0, role_normal = '0, sysclk_mux_internal = '0;
    logic        over_temp = '0, under_volt = '0, energy_seen = '0, sleep_cond = '0;
    logic [11:0] reg_addr = '0, gate_auto_run = '0, clk_enable;
    logic [15:0] reg_wdata = '0, reg_rdata;
    logic        role_select, sysclk_mux_select, energy_detect_enable, energy_detected;
    logic [6:0]  power_state_observe;
    int          n_fail = 0, comparisons = 0;
    lpc_ctrl dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .role_normal(role_normal), .sysclk_mux_internal(sysclk_mux_internal),
        .gate_auto_run(gate_auto_run), .over_temp(over_temp), .under_volt(under_volt), .energy_seen(energy_seen),
        .sleep_cond(sleep_cond), .role_select(role_select), .sysclk_mux_select(sysclk_mux_select),
        .clk_enable(clk_enable), .energy_detect_enable(energy_detect_enable), .energy_detected(energy_detected),
        .power_state_observe(power_state_observe));
    initial forever #25 core_clk = ~core_clk;
    task automatic end_of_test;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string what);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk(what, reg_rdata, exp);
    endtask
    function automatic logic [15:0] obs();
        return {9'h0, power_state_observe};
    endfunction
    task automatic t_reset;
        tick(4);
        chk("state after reset", obs(), 16'h0002);
        rd(lpc_pkg::ADDR_CLK_CTRL, 16'h0, "clock override reset");
        rd(lpc_pkg::ADDR_PS_FORCE, 16'h0, "state force reset");
        rd(lpc_pkg::ADDR_PF_EN, 16'h0040, "autonomous bit set by device");
        rd(lpc_pkg::ADDR_PS_OBS, 16'h0002, "observe register");
        rd(12'h100, 16'h0, "unmapped read");
    endtask
    task automatic t_clk;
        logic [15:0] d;
        for (int i = 0; i < 16; i++) begin
            d = {i[3:0], 12'h001 << i};
            @(posedge core_clk);
            role_normal <= ~i[3];
            sysclk_mux_internal <= ~i[1];
            gate_auto_run <= 12'h00f;
            wr(lpc_pkg::ADDR_CLK_CTRL, d);
            tick(1);
            chk("role select", 16'(role_select), 16'(i[2] ? i[3] : !i[3]));
            chk("sysclk mux select", 16'(sysclk_mux_select), 16'(i[0] ? i[1] : !i[1]));
            chk("clock enables", 16'(clk_enable), 16'(d[11:0] | 12'h00f));
            rd(lpc_pkg::ADDR_CLK_CTRL, d, "clock override readback");
        end
        wr(lpc_pkg::ADDR_CLK_CTRL, 16'h0);
    endtask
    task automatic t_mode;
        wr(lpc_pkg::ADDR_MODE_REQ, 16'h0001);
        tick(2);
        chk("state after normal request", obs(), 16'h0004);
        rd(lpc_pkg::ADDR_MODE_REQ, 16'h0, "normal request cleared");
        wr(lpc_pkg::ADDR_MODE_REQ, 16'h0000);
        tick(2);
        chk("state after zero write", obs(), 16'h0004);
        wr(lpc_pkg::ADDR_MODE_REQ, 16'h0010);
        tick(2);
        chk("state after standby request", obs(), 16'h0002);
        rd(lpc_pkg::ADDR_MODE_REQ, 16'h0, "standby request cleared");
    endtask
    task automatic t_force;
        wr(lpc_pkg::ADDR_PS_FORCE, 16'hff85);
        tick(2);
        chk("forced state", obs(), 16'h0005);
        rd(lpc_pkg::ADDR_PS_FORCE, 16'h0085, "force readback");
        wr(lpc_pkg::ADDR_MODE_REQ, 16'h0001);
        tick(2);
        chk("force holds state", obs(), 16'h0005);
        wr(lpc_pkg::ADDR_PS_FORCE, 16'h0000);
    endtask
    task automatic t_pf;
        wr(lpc_pkg::ADDR_PF_EN, 16'hffe0);
        rd(lpc_pkg::ADDR_PF_EN, 16'h01e0, "feature enable readback");
        @(posedge core_clk);
        energy_seen <= 1'h1;
        tick(4);
        chk("energy detected", 16'(energy_detected), 16'h1);
        wr(lpc_pkg::ADDR_PF_EN, 16'h0000);
        tick(1);
        chk("energy detect enable", 16'(energy_detect_enable), 16'h0);
        chk("energy blocked", 16'(energy_detected), 16'h0);
    endtask
    task automatic t_mon;
        wr(lpc_pkg::ADDR_PF_EN, 16'h0020);
        wr(lpc_pkg::ADDR_MODE_REQ, 16'h0001);
        @(posedge core_clk);
        sleep_cond <= 1'h1;
        tick(8);
        chk("sleep blocked", obs(), 16'h0004);
        @(posedge core_clk);
        over_temp <= 1'h1;
        tick(8);
        chk("fault to standby", obs(), 16'h0002);
        @(posedge core_clk);
        over_temp <= 1'h0;
        wr(lpc_pkg::ADDR_PF_EN, 16'h0000);
        wr(lpc_pkg::ADDR_MODE_REQ, 16'h0001);
        @(posedge core_clk);
        under_volt <= 1'h1;
        tick(8);
        chk("fault ignored", obs(), 16'h0004);
        wr(lpc_pkg::ADDR_PF_EN, 16'h0080);
        tick(2);
        chk("sleep entered", obs(), 16'h0008);
        wr(lpc_pkg::ADDR_PF_EN, 16'h0000);
        tick(2);
        chk("sleep left on permit clear", obs(), 16'h0002);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'h0;
        t_reset;
        t_clk;
        t_mode;
        t_force;
        t_pf;
        t_mon;
        end_of_test;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        end_of_test;
    end
endmodule
bind lpc_ctrl lpc_ctrl_props #(.GATE_W(GATE_W)) props_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .role_normal(role_normal),
    .sysclk_mux_internal(sysclk_mux_internal), .gate_auto_run(gate_auto_run), .role_select(role_select),
    .sysclk_mux_select(sysclk_mux_select), .clk_enable(clk_enable), .energy_detect_enable(energy_detect_enable),
    .energy_detected(energy_detected), .power_state_observe(power_state_observe));
`default_nettype wire
